// File: pkg/dac_mux_regs.svh
// Purpose: Named constants of the dual-port DAC input mux: APB map, fields, resets, timing.
// Assumes: 32-bit APB data, byte addresses, one aligned word per register.
// Notes: Definitions only.
`ifndef DAC_MUX_REGS_SVH
`define DAC_MUX_REGS_SVH

`define CODE_W 12
`define CODE_ALL_ONES 12'hFFF
`define PAIR_W 24
`define FIFO_DEPTH 4
`define FIFO_CNT_W 3

`define ADDR_W 12
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_CODE 12'h008
`define OFF_UPDATES 12'h00C

`define CTRL_OUT_EN_BIT 0
`define CTRL_RESET 1'h1
`define ST_MODE_LSB 0
`define ST_MODE_MSB 4
`define ST_PHASE_BIT 5
`define ST_LOCK_BIT 6
`define ST_CNT_LSB 8
`define ST_CNT_MSB 10
`define UPD_W 16

`define PCLK_PERIOD_NS 8
`define LOCK_TIME_NS 1000
`define LOCK_CYCLES ((`LOCK_TIME_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define LOCK_CNT_W 8

`endif

// File: pkg/dac_mux_pkg.sv
// Purpose: Types of the dual-port DAC input mux.
// Assumes: One-hot input mode codes.
// Notes: Constants live in dac_mux_regs.svh.
package dac_mux_pkg;

  typedef enum logic [4:0] {
    MODE_MULT  = 5'h01,
    MODE_INTLV = 5'h02,
    MODE_PORT1 = 5'h04,
    MODE_PORT2 = 5'h08,
    MODE_BAD   = 5'h10
  } input_mode_t;

endpackage

// File: verilog/dac_input_mux.sv
// Purpose: Input latches, port mux and output latch of a dual-port 12-bit DAC, with APB status.
// Assumes: pclk is the DAC update clock (2x); pins sampled synchronously to pclk.
// Notes: The current outputs are modelled as the true and complement codes.
// Behaviour
// - Multiplier active: capture both ports each rise
// - Same rise: old port 2 to output
// - Half period later: port 1 to output
// - Strap low disables the multiplier
// - Select pins pick interleaved, port1, port2
// - Interleaved: divide 2x clock to 1x
// - Disabled: delayed 1x clock on lock pin
// - Align pulse forces 1x clock high
// - First edge low, second high plus load
// - Align release timing decides lowering edge
// - Non-interleaved: capture selected port each edge
// - Next edge: captured value to output
// - Sample is unsigned 12-bit code
// - Complement output carries 4095 minus code
// - Multiplier active: lock pin shows lock
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "dac_mux_regs.svh"

module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4,
  parameter int CNT_W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CNT_W-1:0] level
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [CNT_W-2:0] wr_ptr_r;
  logic [CNT_W-2:0] rd_ptr_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic ready_r;
  wire push = in_valid && ready_r;
  wire pop = out_valid && out_ready;

  assign cnt_nxt = cnt_r + CNT_W'(push) - CNT_W'(pop);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign in_ready = ready_r;
  assign level = cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      // Registered so the source sees full without a combinational path
      ready_r <= (cnt_nxt != CNT_W'(DEPTH));
    end
  end

  // No reset on storage; a word only counts once written
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule

module dac_input_mux (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample source, one pair per 1x rise (per pclk edge in the port1 and port2 modes)
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [`CODE_W-1:0] port1_data,
  input wire logic [`CODE_W-1:0] port2_data,
  // Mode and alignment pins
  input wire logic multiplier_supply_strap,
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire logic align_reset,
  // Outputs
  output logic lock_or_half_clock_out,
  output logic [`CODE_W-1:0] true_current_out,
  output logic [`CODE_W-1:0] complement_current_out
);
  dac_mux_pkg::input_mode_t mode_r;
  dac_mux_pkg::input_mode_t mode_nxt;
  logic phase_r;
  logic [`CODE_W-1:0] in1_r;
  logic [`CODE_W-1:0] in2_r;
  logic [`CODE_W-1:0] dac_r;
  logic [`CODE_W-1:0] dac_nxt;
  logic [`CODE_W-1:0] compl_r;
  logic [`CODE_W-1:0] single_r;
  logic single_ok_r;
  logic lock_out_r;
  logic [`LOCK_CNT_W-1:0] lock_cnt_r;
  logic locked_r;
  logic out_en_r;
  logic [`UPD_W-1:0] upd_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [`PAIR_W-1:0] fifo_data;
  logic fifo_valid;
  logic [`FIFO_CNT_W-1:0] fifo_level;

  // Mode decode from strap and selects
  wire strap_off = !multiplier_supply_strap;
  wire [1:0] sel_pins = {mode_select_high, mode_select_low};
  always_comb begin
    mode_nxt = dac_mux_pkg::MODE_BAD;
    if (!strap_off) begin
      mode_nxt = dac_mux_pkg::MODE_MULT;
    end else begin
      unique case (sel_pins)
        2'h0: mode_nxt = dac_mux_pkg::MODE_INTLV;
        2'h1: mode_nxt = dac_mux_pkg::MODE_PORT1;
        2'h2: mode_nxt = dac_mux_pkg::MODE_PORT2;
        // Forbidden combination parks the datapath
        2'h3: mode_nxt = dac_mux_pkg::MODE_BAD;
      endcase
    end
  end

  wire is_mult = (mode_r == dac_mux_pkg::MODE_MULT);
  wire is_intlv = (mode_r == dac_mux_pkg::MODE_INTLV);
  wire is_pair = is_mult || is_intlv;
  wire is_single = (mode_r == dac_mux_pkg::MODE_PORT1) || (mode_r == dac_mux_pkg::MODE_PORT2);
  wire align_hit = align_reset && !is_mult;
  wire rise = is_pair && !phase_r && !align_hit;
  wire fall = is_pair && phase_r && !align_hit;
  wire pop_pair = rise && fifo_valid;
  wire pop_single = is_single && fifo_valid;
  wire fifo_pop = pop_pair || pop_single;
  wire [`CODE_W-1:0] f_p1 = fifo_data[`CODE_W-1:0];
  wire [`CODE_W-1:0] f_p2 = fifo_data[`PAIR_W-1:`CODE_W];
  wire [`CODE_W-1:0] f_sel = (mode_r == dac_mux_pkg::MODE_PORT2) ? f_p2 : f_p1;

  // Output latch source; anything else holds the code
  wire load2 = rise && out_en_r;
  wire load1 = fall && out_en_r;
  wire load_s = is_single && single_ok_r && out_en_r;
  wire load_any = load2 || load1 || load_s;
  assign dac_nxt = load2 ? in2_r : load1 ? in1_r : load_s ? single_r : dac_r;

  sample_fifo #(
    .WIDTH(`PAIR_W),
    .DEPTH(`FIFO_DEPTH),
    .CNT_W(`FIFO_CNT_W)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .in_data({port2_data, port1_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data),
    .level(fifo_level)
  );

  // Internal 1x clock as a phase flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= dac_mux_pkg::MODE_MULT;
      phase_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      // Align wins over the toggle, so a held align parks the 1x clock high
      if (align_hit) begin
        phase_r <= 1'b1;
      end else begin
        phase_r <= !phase_r;
      end
    end
  end

  // Input latches; a dry FIFO leaves them unchanged
  // Pops ignore out_en so the stream keeps its pace while the output is frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in1_r <= '0;
      in2_r <= '0;
      single_r <= '0;
      single_ok_r <= 1'b0;
    end else begin
      if (pop_pair) begin
        in1_r <= f_p1;
        in2_r <= f_p2;
      end
      if (pop_single) begin
        single_r <= f_sel;
      end
      single_ok_r <= pop_single;
    end
  end

  // Output latch and current codes
  // Complement in its own flop so both pins switch on one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_r <= '0;
      compl_r <= `CODE_ALL_ONES;
      upd_r <= '0;
    end else begin
      dac_r <= dac_nxt;
      compl_r <= `CODE_ALL_ONES - dac_nxt;
      if (load_any) begin
        upd_r <= upd_r + 1'b1;
      end
    end
  end
  assign true_current_out = dac_r;
  assign complement_current_out = compl_r;

  // Lock model: fixed settle count after the multiplier starts
  // Count restarts whenever the strap drops, as a real loop would relock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_r <= '0;
      locked_r <= 1'b0;
      lock_out_r <= 1'b0;
    end else begin
      if (!is_mult) begin
        lock_cnt_r <= '0;
        locked_r <= 1'b0;
      end else if (lock_cnt_r == `LOCK_CNT_W'(`LOCK_CYCLES)) begin
        locked_r <= 1'b1;
      end else begin
        lock_cnt_r <= lock_cnt_r + 1'b1;
      end
      // One flop of delay stands in for the pad delay
      lock_out_r <= is_mult ? locked_r : phase_r;
    end
  end
  assign lock_or_half_clock_out = lock_out_r;

  // APB slave, zero wait states: answer prepared in the setup cycle
  // Writes to read-only words are dropped without an error
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite && pready_r;
  wire hit_ctrl = (paddr == `OFF_CTRL);
  wire hit_status = (paddr == `OFF_STATUS);
  wire hit_code = (paddr == `OFF_CODE);
  wire hit_upd = (paddr == `OFF_UPDATES);
  wire hit_any = hit_ctrl || hit_status || hit_code || hit_upd;
  wire [31:0] status_word = {21'h000000, fifo_level, 1'b0, locked_r, phase_r, mode_r};
  wire [31:0] rd_mux = hit_ctrl ? {31'h00000000, out_en_r} :
                       hit_status ? status_word :
                       hit_code ? {20'h00000, dac_r} :
                       hit_upd ? {16'h0000, upd_r} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      out_en_r <= `CTRL_RESET;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !hit_any;
      prdata_r <= (setup && !pwrite) ? rd_mux : 32'h00000000;
      if (wr_acc && hit_ctrl) begin
        out_en_r <= pwdata[`CTRL_OUT_EN_BIT];
      end
    end
  end
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pair_capture_a: assert property (pop_pair |=> in1_r == $past(f_p1) && in2_r == $past(f_p2))
    else $error("pair not captured on 1x rise");
  port2_xfer_a: assert property (rise && out_en_r |=> dac_r == $past(in2_r))
    else $error("port 2 latch not moved on rise");
  port1_xfer_a: assert property (rise && out_en_r && is_mult ##1 (is_mult && out_en_r)
    |=> dac_r == $past(in1_r))
    else $error("port 1 latch not moved half period later");
  strap_mode_a: assert property (!multiplier_supply_strap |=> mode_r != dac_mux_pkg::MODE_MULT)
    else $error("multiplier active with strap low");
  strap_high_a: assert property (multiplier_supply_strap |=> is_mult)
    else $error("multiplier not active with strap high");
  align_ignored_a: assert property (is_mult |=> phase_r != $past(phase_r))
    else $error("align input acted while the multiplier runs");
  lock_flag_a: assert property (is_mult ##1 is_mult |-> lock_or_half_clock_out == $past(locked_r))
    else $error("lock pin does not show the lock flag");

  // Mode decode
  select_decode_a: assert property (multiplier_supply_strap == 1'b0 && sel_pins == 2'h1
    |=> mode_r == dac_mux_pkg::MODE_PORT1)
    else $error("select pins decoded wrongly");
  select_intlv_a: assert property (!multiplier_supply_strap && sel_pins == 2'h0 |=> is_intlv)
    else $error("both selects low did not pick interleaved mode");
  select_port2_a: assert property (!multiplier_supply_strap && sel_pins == 2'h2
    |=> mode_r == dac_mux_pkg::MODE_PORT2)
    else $error("high select alone did not pick port 2");

  // Divider and alignment
  half_clock_out_a: assert property (!is_mult ##1 !is_mult |-> lock_or_half_clock_out == $past(phase_r))
    else $error("lock pin is not the delayed 1x clock");
  divide_2x_a: assert property (is_intlv && !align_reset |=> phase_r != $past(phase_r))
    else $error("1x clock did not toggle in interleaved mode");
  align_pin_a: assert property (align_hit ##1 !is_mult |=> lock_or_half_clock_out)
    else $error("lock pin not high after align release");
  align_seq_a: assert property (align_hit ##1 (!align_reset && is_intlv)[*2]
    |-> ($past(phase_r) && !phase_r) ##1 phase_r)
    else $error("align sequence wrong");
  align_load_a: assert property (align_hit ##1 (!align_reset && is_intlv)
    ##1 (!align_reset && is_intlv && fifo_valid) |=> in1_r == $past(f_p1) && in2_r == $past(f_p2))
    else $error("second edge after align did not load the latches");

  // Single-port path, output hold and lock timer
  single_path_a: assert property (pop_single && out_en_r ##1 (is_single && out_en_r)
    |=> dac_r == $past(single_r))
    else $error("single port value not loaded next edge");
  port1_pick_a: assert property (pop_single && mode_r == dac_mux_pkg::MODE_PORT1
    |=> single_r == $past(fifo_data[`CODE_W-1:0]))
    else $error("port 1 mode latched the wrong port");
  port2_pick_a: assert property (pop_single && mode_r == dac_mux_pkg::MODE_PORT2
    |=> single_r == $past(fifo_data[`PAIR_W-1:`CODE_W]))
    else $error("port 2 mode latched the wrong port");
  complement_a: assert property (##1 (13'(true_current_out) + 13'(complement_current_out)) == 13'h0FFF)
    else $error("complement output mismatch");
  output_hold_a: assert property (!load_any |=> $stable(dac_r))
    else $error("output latch changed without a transfer");
  out_en_hold_a: assert property (!out_en_r |=> $stable(true_current_out))
    else $error("output moved while transfers are disabled");
  lock_time_a: assert property (is_mult && !locked_r |-> lock_cnt_r <= `LOCK_CNT_W'(`LOCK_CYCLES))
    else $error("lock counter overran");
  lock_reach_a: assert property (is_mult && lock_cnt_r == `LOCK_CNT_W'(`LOCK_CYCLES) |=> locked_r)
    else $error("lock flag not raised at the settle count");

  intlv_run_c: cover property (is_intlv && pop_pair ##1 load1);
  mult_locked_c: cover property (is_mult && locked_r && pop_pair);
  single_run_c: cover property (pop_single ##1 load_s);
  fifo_full_c: cover property (!src_ready && src_valid);
  align_run_c: cover property (align_hit ##1 !align_reset ##1 !align_reset ##1 pop_pair);
endmodule

// File: verif/sample_source.sv
// Purpose: Parallel sample source feeding the two DAC ports.
// Assumes: Port 1 carries 12'hA00+k, port 2 12'h500+k for pair k.
// Notes: Idle data lines toggle so stale values never pass.
`timescale 1ns/1ps
`include "dac_mux_regs.svh"
module sample_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic enable,
  // Stream to the device
  output logic src_valid,
  input wire logic src_ready,
  output logic [`CODE_W-1:0] port1_data,
  output logic [`CODE_W-1:0] port2_data
);
  logic [`CODE_W-1:0] k_r;
  logic [`CODE_W-1:0] k_nxt;
  assign k_nxt = k_r + {11'h000, src_valid & src_ready};
  // Both ports change together, right after the edge that takes a pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      k_r <= 12'h000;
      src_valid <= 1'b0;
      port1_data <= 12'h000;
      port2_data <= 12'h000;
    end else begin
      k_r <= k_nxt;
      src_valid <= enable;
      port1_data <= enable ? 12'hA00 + k_nxt : ~port1_data;
      port2_data <= enable ? 12'h500 + k_nxt : ~port2_data;
    end
  end
endmodule

// File: verif/testbench.sv
// Purpose: Self-checking bench for the dual-port DAC input mux.
// Assumes: APB answers with pready; source pairs follow a known ramp.
// Notes: Output streams are followed by value, not by fixed latency.
`timescale 1ns/1ps
`include "dac_mux_regs.svh"
`define CHK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("Error %s expected %0h seen %0h", name, exp, got); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic src_valid, src_ready, src_en, strap, sel_lo, sel_hi, align, lock, er;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, u;
  logic [11:0] p1, p2, tru, cmp, v;
  int failures, n_compared;

  dac_input_mux dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_valid(src_valid), .src_ready(src_ready), .port1_data(p1), .port2_data(p2),
    .multiplier_supply_strap(strap), .mode_select_low(sel_lo), .mode_select_high(sel_hi),
    .align_reset(align), .lock_or_half_clock_out(lock), .true_current_out(tru), .complement_current_out(cmp));
  sample_source src_u (.clk(pclk), .rst_n(presetn), .enable(src_en), .src_valid(src_valid),
    .src_ready(src_ready), .port1_data(p1), .port2_data(p2));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic stall(input string what);
    failures++;
    $display("Error %s expected progress seen timeout", what);
    report_and_stop();
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) stall("pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_mode(input logic s, hi, lo, input dac_mux_pkg::input_mode_t m);
    @(posedge pclk);
    strap <= s;
    sel_hi <= hi;
    sel_lo <= lo;
    repeat (3) @(posedge pclk);
    apb(1'b0, `OFF_STATUS, 32'h0);
    `CHK("status mode", m, rd[4:0])
  endtask

  // Lock onto a value of the given port, then expect alternating steps
  task automatic follow(input string name, input logic [3:0] tag, input logic [11:0] sa, sb);
    int i, j;
    for (i = 0; i < 300; i++) begin
      @(negedge pclk);
      if (tru[11:8] === tag) break;
    end
    if (i == 300) stall(name);
    v = tru;
    for (j = 0; j < 8; j++) begin
      for (i = 0; i < 20 && tru === v; i++) @(negedge pclk);
      v = v + ((j % 2) ? sb : sa);
      `CHK(name, v, tru)
      `CHK("complement", 12'hFFF - v, cmp)
    end
    $display("Test %s done", name);
  endtask

  initial begin
    #400000;
    stall("run");
  end

  initial begin
    failures = 0;
    n_compared = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {strap, sel_lo, sel_hi, align, src_en} = 5'h10;
    repeat (20) @(posedge pclk);
    `CHK("true at reset", 12'h000, tru)
    `CHK("complement at reset", 12'hFFF, cmp)
    presetn <= 1'b1;
    apb(1'b0, `OFF_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0000_0001, rd)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    $display("Test registers done");
    set_mode(1'b1, 1'b0, 1'b0, dac_mux_pkg::MODE_MULT);
    src_en <= 1'b1;
    repeat (130) @(posedge pclk);
    `CHK("lock", 1'b1, lock)
    follow("multiplier", 4'hA, 12'hB00, 12'h501);
    apb(1'b1, `OFF_CTRL, 32'h0);
    apb(1'b0, `OFF_UPDATES, 32'h0);
    u = rd;
    v = tru;
    repeat (10) @(posedge pclk);
    apb(1'b0, `OFF_UPDATES, 32'h0);
    `CHK("update count held", u, rd)
    `CHK("output held", v, tru)
    apb(1'b0, `OFF_CODE, 32'h0);
    `CHK("code register", {20'h00000, v}, rd)
    apb(1'b1, `OFF_CTRL, 32'h1);
    $display("Test hold done");
    set_mode(1'b0, 1'b0, 1'b1, dac_mux_pkg::MODE_PORT1);
    follow("port1", 4'hA, 12'h001, 12'h001);
    set_mode(1'b0, 1'b1, 1'b0, dac_mux_pkg::MODE_PORT2);
    follow("port2", 4'h5, 12'h001, 12'h001);
    set_mode(1'b0, 1'b0, 1'b0, dac_mux_pkg::MODE_INTLV);
    @(posedge pclk);
    align <= 1'b1;
    @(posedge pclk);
    align <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    `CHK("half clock after align", 1'b1, lock)
    @(negedge pclk);
    `CHK("half clock first edge", 1'b0, lock)
    @(negedge pclk);
    `CHK("half clock second edge", 1'b1, lock)
    follow("interleaved", 4'hA, 12'hB00, 12'h501);
    report_and_stop();
  end
endmodule
